// ### testbench/timer16_capture_overflow_bench.sv
// Self-checking bench for the 16-bit capture timer
`timescale 1ns/1ns
`include "timer16_defs.svh"
module timer16_capture_overflow_bench;
  logic        clk;
  logic        srst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        irq_a;
  logic        irq_b;
  logic        pulse;
  logic        pin_a;
  logic        pin_b;
  logic        go_a;
  logic        go_b;
  logic        hold_a;
  logic [3:0]  width;
  logic [7:0]  lfsr;
  logic [31:0] rd;
  logic [31:0] c1;
  logic [31:0] cap;
  int          num_errors = 0;
  int          tests_run = 0;
  int          na = 0;
  int          nb = 0;
  int          np = 0;
  int          base;
  int          exp_reg [8] = '{default: 0};
  int          mask [8] = '{32'h7, 32'h7, 32'h3F, 0, 32'hFFFF, 32'hFFFF, 0, 0};

  timer16_capture_overflow timer16_capture_overflow_inst (
    .i_clk(clk), .i_srst(srst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(), .i_trigger_pin_a(pin_a),
    .i_trigger_pin_b(pin_b), .o_capcmp_irq_a(irq_a), .o_capcmp_irq_b(irq_b),
    .o_pulse_out(pulse));
  trig_source trig_source_inst (
    .i_clk(clk), .i_go_a(go_a), .i_go_b(go_b), .i_hold_a(hold_a), .i_width(width),
    .o_pin_a(pin_a), .o_pin_b(pin_b));

  function automatic logic [7:0] next_lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] expd);
    tests_run++;
    if (seen !== expd)
    begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    exp_reg[a[4:2]] = d & mask[a[4:2]];
  endtask
  task automatic rdchk(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
    chk(rd, exp_reg[a[4:2]]);
  endtask
  task automatic trig(input logic on_a, input logic [3:0] w);
    width <= w;
    go_a <= on_a;
    go_b <= !on_a;
    @(posedge clk);
    go_a <= 1'b0;
    go_b <= 1'b0;
    repeat (30) @(posedge clk);
  endtask
  task automatic wrap_up;
    if (num_errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(negedge clk)
  begin
    na = na + (irq_a === 1'b1);
    nb = nb + (irq_b === 1'b1);
    np = np + (pulse === 1'b1);
  end
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    repeat (100000) @(posedge clk);
    num_errors++;
    wrap_up;
  end
  initial
  begin
    srst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    go_a = 1'b0;
    go_b = 1'b0;
    hold_a = 1'b0;
    width = 4'h0;
    lfsr = 8'h36;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 8; i++)
      rdchk(8'(i * 4));
    wr(`TMR_OFS_PRESC, 32'h14);
    wr(`TMR_OFS_CAPCTL, 32'h5);
    lfsr = next_lfsr(lfsr);
    wr(`TMR_OFS_CAPCMP_B, {24'h0, lfsr});
    rdchk(`TMR_OFS_CAPCMP_B);
    rdchk(`TMR_OFS_PRESC);
    hold_a <= 1'b1;
    wr(`TMR_OFS_MODE, 32'h1);
    repeat (30) @(posedge clk);
    chk(nb, 1);
    hold_a <= 1'b0;
    bus(1'b0, `TMR_OFS_COUNT, 32'h0);
    c1 = rd;
    base = na;
    lfsr = next_lfsr(lfsr);
    trig(1'b0, 4'h3 + {2'h0, lfsr[1:0]});
    bus(1'b0, `TMR_OFS_CAPCMP_A, 32'h0);
    cap = rd;
    bus(1'b0, `TMR_OFS_COUNT, 32'h0);
    chk(na - base, 1);
    chk(cap > c1 && cap < rd, 1);
    base = na;
    trig(1'b0, 4'h1);
    chk(na - base, 0);
    // Reverse phase: pin A fall fills reg A silently, pin B only interrupts
    wr(`TMR_OFS_CAPCTL, 32'h7);
    bus(1'b0, `TMR_OFS_CAPCMP_A, 32'h0);
    c1 = rd;
    base = na;
    trig(1'b1, 4'h5);
    bus(1'b0, `TMR_OFS_CAPCMP_A, 32'h0);
    chk(na - base, 0);
    chk(rd !== c1, 1);
    c1 = rd;
    base = na;
    trig(1'b0, 4'h5);
    bus(1'b0, `TMR_OFS_CAPCMP_A, 32'h0);
    chk(na - base, 1);
    chk(rd, c1);
    wr(`TMR_OFS_MODE, 32'h0);
    hold_a <= 1'b1;
    base = na + nb;
    trig(1'b0, 4'h5);
    chk(na + nb - base, 0);
    wr(`TMR_OFS_MODE, 32'h1);
    repeat (30) @(posedge clk);
    chk(na + nb - base, 0);
    wr(`TMR_OFS_MODE, 32'h0);
    hold_a <= 1'b0;
    wr(`TMR_OFS_CAPCTL, 32'h0);
    wr(`TMR_OFS_CAPCMP_A, 32'h40);
    wr(`TMR_OFS_CAPCMP_B, 32'h10);
    base = np;
    wr(`TMR_OFS_MODE, 32'hF);
    repeat (200) @(posedge clk);
    chk(np - base, 0);
    wr(`TMR_OFS_MODE, 32'h0);
    wr(`TMR_OFS_MODE, 32'h5);
    wr(`TMR_OFS_MODE, 32'hD);
    rdchk(`TMR_OFS_MODE);
    repeat (200) @(posedge clk);
    chk(np - base > 0, 1);
    // Pin A as count clock: one count per rise, no capture fed by pin A
    wr(`TMR_OFS_MODE, 32'h0);
    wr(`TMR_OFS_PRESC, 32'h17);
    wr(`TMR_OFS_CAPCTL, 32'h4);
    wr(`TMR_OFS_MODE, 32'h1);
    base = nb;
    repeat (3) trig(1'b1, 4'h4);
    bus(1'b0, `TMR_OFS_COUNT, 32'h0);
    chk(rd, 3);
    chk(nb - base, 0);
    // One-shot in clear-and-start on pin A: high from B match to A match
    wr(`TMR_OFS_MODE, 32'h0);
    wr(`TMR_OFS_PRESC, 32'h14);
    wr(`TMR_OFS_CAPCTL, 32'h0);
    wr(`TMR_OFS_MODE, 32'h6);
    base = np;
    trig(1'b1, 4'h4);
    repeat (60) @(posedge clk);
    chk(np - base, 32'h30);
    // Slow the count just before the wrap so the clear lands inside count zero
    wr(`TMR_OFS_MODE, 32'h0);
    wr(`TMR_OFS_MODE, 32'h1);
    rdchk(`TMR_OFS_STATUS);
    repeat (65400) @(posedge clk);
    bus(1'b1, `TMR_OFS_PRESC, 32'h16);
    for (int i = 0; i < 3000 && !rd[0]; i++)
      bus(1'b0, `TMR_OFS_STATUS, 32'h0);
    bus(1'b1, `TMR_OFS_STATUS, 32'h0);
    bus(1'b0, `TMR_OFS_STATUS, 32'h0);
    chk(rd[0], 1);
    repeat (40) @(posedge clk);
    bus(1'b1, `TMR_OFS_STATUS, 32'h0);
    bus(1'b0, `TMR_OFS_STATUS, 32'h0);
    chk(rd[0], 0);
    bus(1'b0, `TMR_OFS_COUNT, 32'h0);
    chk(rd > 0 && rd < 8, 1);
    wrap_up;
  end
endmodule

// ### testbench/timer16_capture_overflow_props.sv
// Port-level assertions for the 16-bit capture timer
`timescale 1ns/1ns
`include "timer16_defs.svh"
module timer16_capture_overflow_props
(
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  input  wire logic [31:0] o_hrdata,
  input  wire logic        o_hreadyout,
  input  wire logic        o_hresp,
  input  wire logic        o_capcmp_irq_a,
  input  wire logic        o_capcmp_irq_b,
  input  wire logic        o_pulse_out
);
  logic       hit;
  logic       wr_reg;
  logic [1:0] mode_reg;
  logic [2:0] idle_reg;
  assign hit = i_hsel && i_hready && i_htrans[1];
  // Shadow of the run mode, taken from bus writes
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      wr_reg   <= 1'b0;
      mode_reg <= 2'h0;
      idle_reg <= 3'h7;
    end
    else
    begin
      wr_reg <= hit && i_hwrite && i_haddr[7:0] == `TMR_OFS_MODE;
      if (wr_reg)
        mode_reg <= i_hwdata[1:0];
      if (mode_reg != 2'h0)
        idle_reg <= 3'h0;
      else if (idle_reg != 3'h7)
        idle_reg <= idle_reg + 3'h1;
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);
  a_ready_high: assert property (o_hreadyout)
    else $error("hreadyout dropped");
  a_resp_okay: assert property (!o_hresp)
    else $error("response not okay");
  a_reset_quiet: assert property (disable iff (1'b0)
    i_srst |=> !o_capcmp_irq_a && !o_capcmp_irq_b && !o_pulse_out && o_hrdata == 32'h0)
    else $error("outputs active after reset");
  a_stop_quiet: assert property (idle_reg == 3'h7 |-> !o_capcmp_irq_a && !o_capcmp_irq_b)
    else $error("interrupt while stopped");
  a_count_stopped: assert property (hit && !i_hwrite && i_haddr[7:0] == `TMR_OFS_COUNT
    && idle_reg == 3'h7 |=> o_hrdata == 32'h0)
    else $error("count not zero while stopped");
  a_unmapped_read: assert property (hit && !i_hwrite && i_haddr[7:0] > 8'h18
    |=> o_hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_irq_a_single: assert property (mode_reg == 2'h1 && o_capcmp_irq_a |=> !o_capcmp_irq_a)
    else $error("irq a longer than one cycle");
  a_irq_b_single: assert property (mode_reg == 2'h1 && $rose(o_capcmp_irq_b)
    |=> $fell(o_capcmp_irq_b))
    else $error("irq b longer than one cycle");
endmodule
bind timer16_capture_overflow timer16_capture_overflow_props timer16_capture_overflow_props_inst (
  .i_clk(i_clk), .i_srst(i_srst), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
  .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready), .o_hrdata(o_hrdata),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_capcmp_irq_a(o_capcmp_irq_a),
  .o_capcmp_irq_b(o_capcmp_irq_b), .o_pulse_out(o_pulse_out));

// ### testbench/trig_source.sv
// External source of timed pulses on both trigger pins
`timescale 1ns/1ns
module trig_source
(
  input  wire logic       i_clk,
  input  wire logic       i_go_a,
  input  wire logic       i_go_b,
  input  wire logic       i_hold_a,
  input  wire logic [3:0] i_width,
  output logic            o_pin_a,
  output logic            o_pin_b
);
  int left_a = 0;
  int left_b = 0;
  // Width is the bench's choice; short widths are used only as noise
  always @(posedge i_clk)
  begin
    if (i_go_a)
      left_a <= i_width;
    else if (left_a > 0)
      left_a <= left_a - 1;
    if (i_go_b)
      left_b <= i_width;
    else if (left_b > 0)
      left_b <= left_b - 1;
  end
  assign o_pin_a = i_hold_a || left_a > 0;
  assign o_pin_b = left_b > 0;
endmodule

// ### verilog/edge_filter.sv
// Two-sample noise filter with rising and falling edge pulses
`timescale 1ns/1ns
module edge_filter
  import timer16_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_srst,
  input  wire logic i_level,
  input  wire logic i_sample,
  input  wire logic i_track,
  input  wire logic i_report,
  output logic      o_rise,
  output logic      o_fall
);

  filt_state_t st_reg;
  filt_state_t st_next;

  always_comb
  begin
    st_next      = st_reg;
    st_next.rise = 1'b0;
    st_next.fall = 1'b0;
    if (i_sample && i_track)
    begin
      st_next.last = i_level;
      // Level must match on two samples in a row before it counts
      if ((i_level == st_reg.last) && (i_level != st_reg.stable))
      begin
        st_next.stable = i_level;
        // Tracking while stopped keeps an old high level from looking new
        st_next.rise   = i_report & i_level;
        st_next.fall   = i_report & ~i_level;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign o_rise = st_reg.rise;
  assign o_fall = st_reg.fall;

endmodule

// ### verilog/timer16_capture_overflow.sv
// 16-bit timer with two capture/compare registers, AHB-Lite register slave
//
// Behaviour
// - Capture completes even during a register read
// - Valid trigger edge raises capture interrupt
// - Capture registers undefined after stop
// - Counter wrap sets wrap flag
// - Match-clear at FFFFH also sets wrap flag
// - Clear before next count clock is ignored
// - One-shot only in free or edge-clear mode
// - Pin A as count clock disables its captures
// - Capture on tick, interrupt on next tick
// - Reverse-phase capture into A raises nothing
// - Reverse mode: pin B edge is external interrupt
// - First start after reset sees high as rising
// - Restart never reports held high as rising, except on pin B with pin A as count clock
// - Pin A sampled by clock or count tick
// - Edge needs two equal consecutive samples
// - Trigger pins ignored while stopped
//
// Register access over AHB-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "timer16_defs.svh"
module timer16_capture_overflow
  import timer16_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  input  wire logic        i_trigger_pin_a,
  input  wire logic        i_trigger_pin_b,
  output logic             o_capcmp_irq_a,
  output logic             o_capcmp_irq_b,
  output logic             o_pulse_out
);

  tmr_state_t st_reg;
  tmr_state_t st_next;

  logic a_rise;
  logic a_fall;
  logic b_rise;
  logic b_fall;

  function automatic logic edge_hit(input edge_sel_t sel, input logic r, input logic f);
    case (sel)
      EDGE_FALL: edge_hit = f;
      EDGE_RISE: edge_hit = r;
      EDGE_BOTH: edge_hit = r | f;
      default:   edge_hit = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] reg_read(input logic [7:0] addr, input tmr_state_t s);
    reg_read = `TMR_RDATA_RST;
    case (addr)
      `TMR_OFS_MODE:
      begin
        reg_read[`TMR_MODE_RUN_HI:`TMR_MODE_RUN_LO] = s.mode;
        reg_read[`TMR_MODE_OS_EN]                   = s.os_en;
      end
      `TMR_OFS_CAPCTL:
      begin
        reg_read[`TMR_CAPCTL_A_CAP] = s.a_cap;
        reg_read[`TMR_CAPCTL_REV]   = s.rev_sel;
        reg_read[`TMR_CAPCTL_B_CAP] = s.b_cap;
      end
      `TMR_OFS_PRESC:
      begin
        reg_read[`TMR_PRESC_SEL_HI:`TMR_PRESC_SEL_LO] = s.clk_sel;
        reg_read[`TMR_PRESC_EA_HI:`TMR_PRESC_EA_LO]   = s.edge_a;
        reg_read[`TMR_PRESC_EB_HI:`TMR_PRESC_EB_LO]   = s.edge_b;
      end
      `TMR_OFS_COUNT:    reg_read[15:0] = s.count;
      `TMR_OFS_CAPCMP_A: reg_read[15:0] = s.capcmp_a;
      `TMR_OFS_CAPCMP_B: reg_read[15:0] = s.capcmp_b;
      `TMR_OFS_STATUS:
      begin
        reg_read[`TMR_STAT_WRAP]  = s.wrap_flag;
        reg_read[`TMR_STAT_PULSE] = s.pulse;
      end
      default:           reg_read = `TMR_RDATA_RST;
    endcase
  endfunction

  logic running;
  logic pin_a_clk;
  logic tick;
  logic sample_a;
  logic a_valid;
  logic a_rev;
  logic b_valid;
  logic addr_ph;
  logic wr_mode;
  logic wr_capctl;
  logic wr_presc;
  logic wr_cap_a;
  logic wr_cap_b;
  logic wr_stat;
  logic cap_a_evt;
  logic cap_b_evt;
  logic ext_a_evt;
  logic match_a;
  logic match_b;
  logic wrap_evt;
  logic os_trig;
  logic os_ok;

  assign running   = (st_reg.mode != RUN_STOP);
  assign pin_a_clk = (st_reg.clk_sel == CLK_PIN_A);

  // Pin A filter runs on the system clock when it is the count clock
  assign sample_a = pin_a_clk ? 1'b1 : tick;

  edge_filter u_filt_a (
    .i_clk    (i_clk),
    .i_srst   (i_srst),
    .i_level  (st_reg.sync_a[1]),
    .i_sample (sample_a),
    .i_track  (running | st_reg.started),
    .i_report (running),
    .o_rise   (a_rise),
    .o_fall   (a_fall)
  );

  edge_filter u_filt_b (
    .i_clk    (i_clk),
    .i_srst   (i_srst),
    .i_level  (st_reg.sync_b[1]),
    .i_sample (tick),
    .i_track  (running | st_reg.started),
    .i_report (running),
    .o_rise   (b_rise),
    .o_fall   (b_fall)
  );

  always_comb
  begin
    // Free-running prescaler; pin A edges replace it when selected
    case (st_reg.clk_sel)
      CLK_DIV1:  tick = 1'b1;
      CLK_DIV4:  tick = (st_reg.presc[1:0] == `TMR_PRE_DIV4);
      CLK_DIV16: tick = (st_reg.presc == `TMR_PRE_DIV16);
      CLK_PIN_A: tick = edge_hit(st_reg.edge_a, a_rise, a_fall);
      default:   tick = 1'b0;
    endcase
  end

  assign a_valid = edge_hit(st_reg.edge_a, a_rise, a_fall);
  assign a_rev   = (st_reg.edge_a == EDGE_RISE) ? a_fall :
                   (st_reg.edge_a == EDGE_FALL) ? a_rise : 1'b0;
  assign b_valid = edge_hit(st_reg.edge_b, b_rise, b_fall);

  assign addr_ph   = i_hsel & i_hready & i_htrans[1];
  assign wr_mode   = st_reg.dp_write && (st_reg.dp_addr == `TMR_OFS_MODE);
  assign wr_capctl = st_reg.dp_write && (st_reg.dp_addr == `TMR_OFS_CAPCTL);
  assign wr_presc  = st_reg.dp_write && (st_reg.dp_addr == `TMR_OFS_PRESC);
  assign wr_cap_a  = st_reg.dp_write && (st_reg.dp_addr == `TMR_OFS_CAPCMP_A);
  assign wr_cap_b  = st_reg.dp_write && (st_reg.dp_addr == `TMR_OFS_CAPCMP_B);
  assign wr_stat   = st_reg.dp_write && (st_reg.dp_addr == `TMR_OFS_STATUS);

  // Captures fed by pin A would sample a count that pin A itself moves
  assign cap_a_evt = running & st_reg.a_cap &
                     (st_reg.rev_sel ? (a_rev & ~pin_a_clk) : b_valid);
  assign ext_a_evt = running & st_reg.a_cap & st_reg.rev_sel & b_valid;
  assign cap_b_evt = running & st_reg.b_cap & a_valid & ~pin_a_clk;

  assign match_a  = running & tick & ~st_reg.a_cap & (st_reg.count == st_reg.capcmp_a);
  assign match_b  = running & tick & ~st_reg.b_cap & (st_reg.count == st_reg.capcmp_b);
  assign wrap_evt = running & tick & (st_reg.count == `TMR_CNT_MAX);

  assign os_ok   = (st_reg.mode == RUN_FREE) || (st_reg.mode == RUN_EDGE);
  assign os_trig = st_reg.os_en & os_ok & (st_reg.os == OS_IDLE) &
                   ((wr_mode & i_hwdata[`TMR_MODE_OS_TRIG]) |
                    ((st_reg.mode == RUN_EDGE) & a_valid));

  always_comb
  begin
    st_next        = st_reg;
    st_next.irq_a  = 1'b0;
    st_next.irq_b  = 1'b0;
    st_next.sync_a = {st_reg.sync_a[0], i_trigger_pin_a};
    st_next.sync_b = {st_reg.sync_b[0], i_trigger_pin_b};
    st_next.presc  = st_reg.presc + `TMR_PRE_ONE;

    // Register writes land in the data phase after the address phase
    st_next.dp_write = addr_ph & i_hwrite;
    st_next.dp_addr  = i_haddr[7:0];
    if (addr_ph && !i_hwrite)
      st_next.rdata = reg_read(i_haddr[7:0], st_reg);

    if (wr_mode)
    begin
      st_next.mode  = run_mode_t'(i_hwdata[`TMR_MODE_RUN_HI:`TMR_MODE_RUN_LO]);
      st_next.os_en = i_hwdata[`TMR_MODE_OS_EN];
    end
    if (wr_capctl)
    begin
      st_next.a_cap   = i_hwdata[`TMR_CAPCTL_A_CAP];
      st_next.rev_sel = i_hwdata[`TMR_CAPCTL_REV];
      st_next.b_cap   = i_hwdata[`TMR_CAPCTL_B_CAP];
    end
    // Edge select taken as written; software keeps the timer stopped
    if (wr_presc)
    begin
      st_next.clk_sel = clk_sel_t'(i_hwdata[`TMR_PRESC_SEL_HI:`TMR_PRESC_SEL_LO]);
      st_next.edge_a  = edge_sel_t'(i_hwdata[`TMR_PRESC_EA_HI:`TMR_PRESC_EA_LO]);
      st_next.edge_b  = edge_sel_t'(i_hwdata[`TMR_PRESC_EB_HI:`TMR_PRESC_EB_LO]);
    end
    if (wr_cap_a)
      st_next.capcmp_a = i_hwdata[15:0];
    if (wr_cap_b)
      st_next.capcmp_b = i_hwdata[15:0];

    if (running)
      st_next.started = 1'b1;

    if (!running)
    begin
      // Stopped: count held at zero, no pending events; capture values kept
      st_next.count     = `TMR_CNT_RST;
      st_next.pend_a    = 1'b0;
      st_next.pend_b    = 1'b0;
      st_next.wrap_hold = 1'b0;
      st_next.os        = OS_IDLE;
      st_next.pulse     = 1'b0;
    end
    else
    begin
      if (tick)
      begin
        if ((st_reg.mode == RUN_MATCH) && (st_reg.count == st_reg.capcmp_a))
          st_next.count = `TMR_CNT_RST;
        else
          st_next.count = st_reg.count + `TMR_CNT_ONE;
        st_next.wrap_hold = 1'b0;
        // Interrupts of captures taken since the last tick go out now
        st_next.irq_a  = st_reg.pend_a | match_a;
        st_next.irq_b  = st_reg.pend_b | match_b;
        st_next.pend_a = 1'b0;
        st_next.pend_b = 1'b0;
      end
      if ((st_reg.mode == RUN_EDGE) && a_valid)
        st_next.count = `TMR_CNT_RST;
      if (wrap_evt)
        st_next.wrap_hold = 1'b1;

      // Reverse-phase capture into A queues no interrupt
      if (cap_a_evt)
      begin
        st_next.capcmp_a = st_reg.count;
        if (!st_reg.rev_sel)
          st_next.pend_a = 1'b1;
      end
      if (ext_a_evt)
        st_next.pend_a = 1'b1;
      if (cap_b_evt)
      begin
        st_next.capcmp_b = st_reg.count;
        st_next.pend_b   = 1'b1;
      end

      case (st_reg.os)
        OS_IDLE:
        begin
          if (os_trig)
            st_next.os = OS_WAIT;
        end
        OS_WAIT:
        begin
          if (tick && (st_reg.count == st_reg.capcmp_b))
          begin
            st_next.os    = OS_ACTIVE;
            st_next.pulse = 1'b1;
          end
        end
        OS_ACTIVE:
        begin
          if (tick && (st_reg.count == st_reg.capcmp_a))
          begin
            st_next.os    = OS_IDLE;
            st_next.pulse = 1'b0;
          end
        end
        default:
        begin
          st_next.os    = OS_IDLE;
          st_next.pulse = 1'b0;
        end
      endcase
      if (!os_ok)
      begin
        st_next.os    = OS_IDLE;
        st_next.pulse = 1'b0;
      end
    end

    // Clear only outside the hold window; a fresh wrap always wins
    if (wr_stat && !i_hwdata[`TMR_STAT_WRAP] && !st_reg.wrap_hold)
      st_next.wrap_flag = 1'b0;
    if (wrap_evt)
      st_next.wrap_flag = 1'b1;
  end

  always_ff @(posedge i_clk)
  begin
    // All-zero state is stopped, undivided clock, falling edges
    if (i_srst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // Zero wait states; every access completes OKAY
  assign o_hreadyout    = 1'b1;
  assign o_hresp        = 1'b0;
  assign o_hrdata       = st_reg.rdata;
  assign o_capcmp_irq_a = st_reg.irq_a;
  assign o_capcmp_irq_b = st_reg.irq_b;
  assign o_pulse_out    = st_reg.pulse;

endmodule

// ### verilog/timer16_defs.svh
// Register offsets, field positions, reset values and timing counts of the timer
`ifndef TIMER16_DEFS_SVH
`define TIMER16_DEFS_SVH

`define TMR_OFS_MODE      8'h00
`define TMR_OFS_CAPCTL    8'h04
`define TMR_OFS_PRESC     8'h08
`define TMR_OFS_COUNT     8'h0C
`define TMR_OFS_CAPCMP_A  8'h10
`define TMR_OFS_CAPCMP_B  8'h14
`define TMR_OFS_STATUS    8'h18

`define TMR_MODE_RUN_LO   0
`define TMR_MODE_RUN_HI   1
`define TMR_MODE_OS_EN    2
`define TMR_MODE_OS_TRIG  3

`define TMR_CAPCTL_A_CAP  0
`define TMR_CAPCTL_REV    1
`define TMR_CAPCTL_B_CAP  2

`define TMR_PRESC_SEL_LO  0
`define TMR_PRESC_SEL_HI  1
`define TMR_PRESC_EA_LO   2
`define TMR_PRESC_EA_HI   3
`define TMR_PRESC_EB_LO   4
`define TMR_PRESC_EB_HI   5

`define TMR_STAT_WRAP     0
`define TMR_STAT_PULSE    1

`define TMR_CNT_RST       16'h0000
`define TMR_CNT_MAX       16'hFFFF
`define TMR_CNT_ONE       16'h0001
`define TMR_PRE_RST       4'h0
`define TMR_PRE_DIV4      4'h3
`define TMR_PRE_DIV16     4'hF
`define TMR_PRE_ONE       4'h1
`define TMR_RDATA_RST     32'h0000_0000

`endif

// ### verilog/timer16_pkg.sv
// Types shared by the timer and its input filter
package timer16_pkg;

  typedef enum logic [1:0] {
    RUN_STOP  = 2'b00,
    RUN_FREE  = 2'b01,
    RUN_EDGE  = 2'b10,
    RUN_MATCH = 2'b11
  } run_mode_t;

  typedef enum logic [1:0] {
    CLK_DIV1  = 2'b00,
    CLK_DIV4  = 2'b01,
    CLK_DIV16 = 2'b10,
    CLK_PIN_A = 2'b11
  } clk_sel_t;

  typedef enum logic [1:0] {
    EDGE_FALL = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_NONE = 2'b10,
    EDGE_BOTH = 2'b11
  } edge_sel_t;

  typedef enum logic [1:0] {
    OS_IDLE   = 2'b00,
    OS_WAIT   = 2'b01,
    OS_ACTIVE = 2'b10
  } os_state_t;

  typedef struct packed {
    logic        last;
    logic        stable;
    logic        rise;
    logic        fall;
  } filt_state_t;

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] capcmp_a;
    logic [15:0] capcmp_b;
    run_mode_t   mode;
    logic        os_en;
    logic        a_cap;
    logic        rev_sel;
    logic        b_cap;
    clk_sel_t    clk_sel;
    edge_sel_t   edge_a;
    edge_sel_t   edge_b;
    logic        wrap_flag;
    logic        wrap_hold;
    logic [3:0]  presc;
    logic        pend_a;
    logic        pend_b;
    logic        irq_a;
    logic        irq_b;
    os_state_t   os;
    logic        pulse;
    logic        started;
    logic [1:0]  sync_a;
    logic [1:0]  sync_b;
    logic        dp_write;
    logic [7:0]  dp_addr;
    logic [31:0] rdata;
  } tmr_state_t;

endpackage
